/* port_status_update.sv */
`timescale 1ns/1ps
`default_nettype none
module port_status_update
	import pts_pkg::*;
#(
	parameter int TIMEOUT_CYC = REPLY_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic extended_line_diag_enable,
	input wire logic xfer_valid,
	input wire xfer_event_t xfer,
	input wire logic md_rx,
	input wire port_cfg_t md_cfg,
	input wire logic sd_rx,
	output logic busy,
	output logic tm_req,
	output logic tm_we,
	output logic [ADDR_W-1:0] tm_addr,
	output logic [WORD_W-1:0] tm_wdata,
	input wire logic [WORD_W-1:0] tm_rdata,
	input wire logic tm_ack,
	output logic upd_done,
	output logic [WORD_W-1:0] status_word,
	output logic tx_page,
	output logic rx_page,
	output logic port_temp_disabled
);

	// =========================================================
	// working registers
	upd_state_t state_r, state_nxt;
	xfer_event_t ev_r;
	port_cfg_t tcfg_r;
	logic [WORD_W-1:0] old_r;
	logic [WORD_W-1:0] new_nxt;
	logic timeout;
	logic take_xfer, take_to;
	logic sink_only;

	// =========================================================
	// reply timeout
	// timeout raises update
	reply_timer #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(md_rx),
		.stop(sd_rx | xfer_valid),
		.expired(timeout)
	);


	// port info for the timeout event
	// held so a late expiry still names its port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tcfg_r <= '0;
		end else if (md_rx) begin
			tcfg_r <= md_cfg;
		end
	end

	// =========================================================
	// event acceptance
	// inactive or mismatched frame ignored
	assign take_xfer = xfer_valid && (state_r == ST_IDLE) && xfer.cfg.active
		&& !xfer.mf_in_sf_slot && !extended_line_diag_enable;
	assign take_to = timeout && !xfer_valid && (state_r == ST_IDLE) && tcfg_r.active
		&& !extended_line_diag_enable;

	// timeout loses to a transfer in the same cycle
	// timeout event carries only the timeout flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_r <= '0;
		end else if (take_xfer) begin
			ev_r <= xfer;
		end else if (take_to) begin
			ev_r.cfg <= tcfg_r;
			ev_r.ok <= 1'b0;
			ev_r.mf_in_sf_slot <= 1'b0;
			ev_r.stored <= 1'b0;
			ev_r.errs <= ERR_TIMEOUT;
		end
	end


	// sink-only ports own the page toggle and disable
	assign sink_only = ev_r.cfg.sink_port_flag && !ev_r.cfg.source_port_flag;

	// =========================================================
	// new status word
	// built from the word read back, never from reset
	always_comb begin
		new_nxt = old_r;
		new_nxt[DEC_MSB:DEC_LSB] = old_r[DEC_MSB:DEC_LSB];
		new_nxt[ERR_W-1:0] = ev_r.ok ? ERR_NONE : ev_r.errs;
		new_nxt[PTD_BIT] = (old_r[DEC_MSB:DEC_LSB] != DEC_ZERO);
		if (sink_only && (ev_r.ok || (ev_r.stored && ev_r.cfg.write_always_option))) begin
			new_nxt[VP_BIT] = ~old_r[VP_BIT];
		end
	end

	// =========================================================
	// update sequencer
	// read, calc, write; back to idle on write ack
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (take_xfer || take_to) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				if (tm_ack) begin
					state_nxt = ST_CALC;
				end
			end
			ST_CALC: begin
				// one cycle for the new word to settle
				state_nxt = ST_WRITE;
			end
			ST_WRITE: begin
				if (tm_ack) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end


	// word content comes only from memory
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			old_r <= WORD_RST;
		end else if (state_r == ST_READ && tm_ack) begin
			old_r <= tm_rdata;
		end
	end

	// =========================================================
	// traffic memory port
	// read-modify-write of word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tm_req <= 1'b0;
			tm_we <= 1'b0;
			tm_addr <= ADDR_RST;
			tm_wdata <= WORD_RST;
		end else begin
			// read request on acceptance
			if (state_nxt == ST_READ && state_r == ST_IDLE) begin
				tm_req <= 1'b1;
				tm_we <= 1'b0;
				tm_addr <= take_xfer ? xfer.cfg.word_addr : tcfg_r.word_addr;
			// write request after one calc cycle
			end else if (state_r == ST_CALC) begin
				tm_req <= 1'b1;
				tm_we <= 1'b1;
				tm_wdata <= new_nxt;
			// drop request once answered
			end else if (tm_ack) begin
				tm_req <= 1'b0;
				tm_we <= 1'b0;
			end
		end
	end


	// busy tracks next state so events see it at once
	// done pulses one cycle after the write is acknowledged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			upd_done <= 1'b0;
		end else begin
			busy <= (state_nxt != ST_IDLE);
			upd_done <= (state_r == ST_WRITE) && tm_ack;
		end
	end

	// =========================================================
	// page selection and port disable
	// outputs only move when the write lands
	// so the host never sees a half-done word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_word <= WORD_RST;
			tx_page <= 1'b0;
			rx_page <= 1'b0;
			port_temp_disabled <= 1'b0;
		end else if (state_r == ST_WRITE && tm_ack) begin
			status_word <= tm_wdata;
			tx_page <= tm_wdata[VP_BIT];
			rx_page <= ~tm_wdata[VP_BIT];
			port_temp_disabled <= tm_wdata[PTD_BIT] && sink_only;
		end
	end

endmodule
`default_nettype wire

/* pts_pkg.sv */
package pts_pkg;

	// =========================================================
	// status word field layout
	localparam int WORD_W = 16;
	localparam int DEC_MSB = 15;
	localparam int DEC_LSB = 8;
	localparam int DEC_W = 8;
	localparam int PTD_BIT = 7;
	localparam int VP_BIT = 6;
	localparam int ERR_W = 6;
	localparam int CRC_BIT = 5;
	localparam int SQE_BIT = 4;
	localparam int ALO_BIT = 3;
	localparam int BNI_BIT = 2;
	localparam int TELEGRAM_ERROR_FLAG_BIT = 1;
	localparam int STO_BIT = 0;
	localparam int ADDR_W = 16;

	// =========================================================
	// timing
	localparam int CLK_MHZ = 200;
	localparam int REPLY_TIMEOUT_NS = 42700; // 42.7 us
	localparam int REPLY_TIMEOUT_CYC = (REPLY_TIMEOUT_NS * CLK_MHZ) / 1000;
	localparam int TIMER_W = 16;

	localparam logic [ERR_W-1:0] ERR_NONE = 6'h00;
	localparam logic [ERR_W-1:0] ERR_TIMEOUT = 6'h01;
	localparam logic [DEC_W-1:0] DEC_ZERO = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

	// =========================================================
	// port configuration carried with each event
	typedef struct packed {
		logic [ADDR_W-1:0] word_addr; // status word location in traffic memory
		logic source_port_flag;
		logic sink_port_flag;
		logic active;
		logic write_always_option;
	} port_cfg_t;

	// outcome of one transfer, reported by the telegram engine
	typedef struct packed {
		port_cfg_t cfg;
		logic ok;            // transfer successful
		logic mf_in_sf_slot; // master frame arrived while slave frame expected
		logic stored;        // received data went to traffic memory
		logic [ERR_W-1:0] errs;
	} xfer_event_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_CALC = 2'b11,
		ST_WRITE = 2'b10
	} upd_state_t;

endpackage

/* reply_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module reply_timer
	import pts_pkg::*;
#(
	parameter int TIMEOUT_CYC = REPLY_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic stop,
	output logic expired
);

	logic [TIMER_W-1:0] cnt_r;
	logic run_r;
	localparam logic [TIMER_W-1:0] LAST = TIMER_W'(TIMEOUT_CYC - 1);

	// =========================================================
	// wait for slave delimiter after master delimiter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				cnt_r <= '0;
				run_r <= 1'b1;
			end else if (stop) begin
				run_r <= 1'b0;
			end else if (run_r) begin
				if (cnt_r == LAST) begin
					run_r <= 1'b0;
					expired <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

/* pts_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pts_props import pts_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic extended_line_diag_enable,
	input wire logic xfer_valid,
	input wire xfer_event_t xfer,
	input wire logic md_rx,
	input wire port_cfg_t md_cfg,
	input wire logic busy,
	input wire logic tm_req,
	input wire logic tm_we,
	input wire logic [WORD_W-1:0] tm_wdata,
	input wire logic [WORD_W-1:0] tm_rdata,
	input wire logic tm_ack,
	input wire logic upd_done,
	input wire logic [WORD_W-1:0] status_word,
	input wire logic tx_page,
	input wire logic rx_page,
	input wire logic port_temp_disabled
);
	logic [WORD_W-1:0] rd_r;
	logic ok_r, src_r, snk_r, wr;
	assign wr = tm_req && tm_we;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// =========================================================
	// read word and event kind of the running update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_r <= WORD_RST;
			{ok_r, src_r, snk_r} <= 3'h0;
		end else begin
			if (tm_req && !tm_we && tm_ack) rd_r <= tm_rdata;
			if (xfer_valid && !busy) {ok_r, src_r, snk_r} <= {xfer.ok, xfer.cfg.source_port_flag, xfer.cfg.sink_port_flag};
			else if (md_rx) {ok_r, src_r, snk_r} <= {1'b0, md_cfg.source_port_flag, md_cfg.sink_port_flag};
		end
	end
	// =========================================================
	// assertions
	cnt_kept_a: assert property (wr |-> tm_wdata[15:8] == rd_r[15:8]) else $error("counter changed");
	ptd_rule_a: assert property (wr |-> tm_wdata[7] == (rd_r[15:8] != 8'h00)) else $error("bad disable flag");
	err_clear_a: assert property (wr && ok_r |-> tm_wdata[5:0] == ERR_NONE) else $error("errors kept");
	src_page_a: assert property (wr && src_r |-> tm_wdata[6] == rd_r[6]) else $error("source page moved");
	snk_page_a: assert property (wr && snk_r && !src_r && ok_r |-> tm_wdata[6] != rd_r[6])
		else $error("no page flip");
	drop_evt_a: assert property (xfer_valid && !busy && (!xfer.cfg.active || xfer.mf_in_sf_slot
		|| extended_line_diag_enable) |=> !busy) else $error("event not dropped");
	read_first_a: assert property ($rose(busy) |-> tm_req && !tm_we) else $error("no read first");
	done_after_a: assert property (wr && tm_ack |=> upd_done && !busy && status_word == $past(tm_wdata))
		else $error("bad completion");
	page_out_a: assert property (upd_done |-> tx_page == status_word[6] && rx_page != tx_page
		&& port_temp_disabled == (status_word[7] && snk_r && !src_r)) else $error("bad outputs");
	cover property (wr && src_r);
	cover property (wr && snk_r && !src_r && ok_r);
	cover property ($rose(busy) && !xfer_valid);
endmodule
bind port_status_update pts_props u_props (.*);
`default_nettype wire

/* tm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tm_host import pts_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tm_req,
	input wire logic tm_we,
	input wire logic [ADDR_W-1:0] tm_addr,
	input wire logic [WORD_W-1:0] tm_wdata,
	input wire logic [1:0] lat,
	output logic tm_ack,
	output logic [WORD_W-1:0] tm_rdata
);
	logic [WORD_W-1:0] mem [16];
	logic [1:0] cnt_r;
	// answers each access after lat wait cycles
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tm_ack <= 1'b0;
			cnt_r <= 2'h0;
			tm_rdata <= 16'h5A5A;
		end else begin
			tm_ack <= 1'b0;
			tm_rdata <= ~tm_rdata; // no stale data outside reads
			if (tm_req && !tm_ack) begin
				cnt_r <= cnt_r + 2'h1;
				if (cnt_r >= lat) begin
					tm_ack <= 1'b1;
					cnt_r <= 2'h0;
					if (tm_we) mem[tm_addr[3:0]] <= tm_wdata;
					else tm_rdata <= mem[tm_addr[3:0]];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* port_status_update_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module port_status_update_tb import pts_pkg::*;;
	logic clk = 0, rst_n = 0, extended_line_diag_enable = 0, xfer_valid = 0, md_rx = 0, sd_rx = 0;
	xfer_event_t xfer = '0, e;
	port_cfg_t md_cfg = '0;
	logic [1:0] lat = 2'h0;
	logic busy, tm_req, tm_we, tm_ack, upd_done, tx_page, rx_page, port_temp_disabled;
	logic [15:0] tm_addr, tm_wdata, tm_rdata, status_word;
	logic [31:0] s = 32'h00003EA0, r;
	int errors = 0, check_count = 0, cyc = 0, i;
	port_status_update #(.TIMEOUT_CYC(20)) u_dut (.*);
	tm_host u_mem (.*);
	initial forever #2.5 clk = ~clk;
	// cycle ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc > 60000) begin
			errors++;
			summarize();
		end
	end
	function logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// expected word after one update
	function logic [15:0] nx(logic [15:0] o, xfer_event_t v);
		nx = o;
		nx[7] = o[15:8] != DEC_ZERO;
		if (v.cfg.sink_port_flag && !v.cfg.source_port_flag && (v.ok || v.stored && v.cfg.write_always_option)) nx[6] = ~o[6];
		nx[5:0] = v.ok ? ERR_NONE : v.errs;
	endfunction
	task chk(logic [15:0] g, logic [15:0] x);
		check_count++;
		if (g !== x) begin
			$display("Error t=%0t got=%h exp=%h", $time, g, x);
			errors++;
		end
	endtask
	task go(xfer_event_t v, bit tmo, bit take);
		logic [15:0] o;
		logic [3:0] a;
		a = v.cfg.word_addr[3:0];
		if (v.cfg.source_port_flag) u_mem.mem[a][6] = ~u_mem.mem[a][6];
		o = u_mem.mem[a];
		if (tmo) {v.ok, v.stored, v.errs} = {2'b00, ERR_TIMEOUT};
		@(posedge clk);
		if (tmo) {md_rx, md_cfg} <= {1'b1, v.cfg};
		else {xfer_valid, xfer} <= {1'b1, v};
		@(posedge clk);
		{xfer_valid, md_rx, sd_rx} <= {2'b00, tmo && !take};
		@(posedge clk);
		sd_rx <= 1'b0;
		for (int k = 0; k < 80; k++) begin
			@(posedge clk);
			#1;
			if (upd_done === 1'b1) break;
		end
		chk(u_mem.mem[a], take ? nx(o, v) : o);
		if (take) chk(status_word, nx(o, v));
	endtask
	task summarize();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		for (i = 0; i < 16; i++) begin
			r = rnd();
			u_mem.mem[i] = r[15:0];
		end
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 40; i++) begin
			r = rnd();
			e = xfer_event_t'(r[28:0]);
			{e.cfg.active, e.mf_in_sf_slot, e.cfg.word_addr} = {2'b10, 12'h000, r[3:0]};
			lat <= r[31:30];
			if (i < 2) u_mem.mem[r[3:0]][15:8] = DEC_ZERO;
			go(e, i % 8 == 7, 1);
		end
		$display("random events done");
		e.cfg.active = 1'b0;
		go(e, 0, 0);
		{e.cfg.active, e.mf_in_sf_slot} = 2'b11;
		go(e, 0, 0);
		e.mf_in_sf_slot = 1'b0;
		extended_line_diag_enable <= 1'b1;
		go(e, 0, 0);
		extended_line_diag_enable <= 1'b0;
		go(e, 1, 0);
		$display("corner events done");
		summarize();
	end
endmodule
`default_nettype wire
